// ===== sata_drive_model.sv
// behavioural model of the attached drive
`timescale 1ns/1ps
module sata_drive_model #(parameter int TIMEOUT = 100) (
  input  wire logic                  i_clk,
  input  wire logic                  i_en,
  input  wire logic                  i_deaf,
  input  wire logic [1:0]            i_max_gen,
  input  wire sata_neg_pkg::tx_ctl_s i_tx,
  output sata_neg_pkg::rx_ind_s      o_rx
);
  logic [1:0] gen_q;
  logic [1:0] seen_gen;
  int         cnt_q;
  logic       linked_q;
  initial o_rx = '0;
  // top rate shows a one-cycle false gen2 hit now and then, like aliasing
  assign seen_gen = (gen_q == sata_neg_pkg::GEN3 && cnt_q[3:0] == 4'hF) ? sata_neg_pkg::GEN2 : gen_q;
  // rising edge, so the bench's falling-edge stimulus never races the model
  always @(posedge i_clk) begin
    if (!i_en) begin
      gen_q <= i_max_gen;
      cnt_q <= 0;
      linked_q <= 1'b0;
      // silent line keeps changing so a stale value never looks valid
      o_rx <= {1'b0, ~o_rx.align_gen, 2'b00};
    end else if (linked_q) begin
      o_rx <= {1'b0, 2'b00, 1'b1, 1'b0};
    end else if (!i_deaf && i_tx.pattern == sata_neg_pkg::TX_ALIGN && i_tx.gen == gen_q) begin
      linked_q <= 1'b1;
    end else if (cnt_q == TIMEOUT - 1) begin
      cnt_q <= 0;
      o_rx.cominit <= (gen_q == sata_neg_pkg::GEN1);
      gen_q <= (gen_q == sata_neg_pkg::GEN1) ? i_max_gen : gen_q - 2'h1;
    end else begin
      cnt_q <= cnt_q + 1;
      o_rx <= {1'b1, seen_gen, 2'b00};
    end
  end
endmodule // sata_drive_model

// ===== sata_host_speed_negotiation.sv
// host side speed negotiation state machine
`timescale 1ns/1ps
module sata_host_speed_negotiation #(
  parameter int DETECT_CYCLES = sata_neg_pkg::DETECT_CYC,
  parameter int ANSWER_WAIT   = sata_neg_pkg::ANSWER_WAIT_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_port_reset,
  input  wire sata_neg_pkg::rx_ind_s i_rx,
  output sata_neg_pkg::tx_ctl_s      o_tx,
  output logic                       o_link_up,
  output logic [1:0]                 o_link_gen,
  output logic                       o_restart
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DETECT_CYCLES < 1 || DETECT_CYCLES > 255) begin : g_bad_detect
    $error("DETECT_CYCLES out of range");
  end
  if (ANSWER_WAIT < 1 || ANSWER_WAIT > 65535) begin : g_bad_wait
    $error("ANSWER_WAIT out of range");
  end

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  // phy indications arrive from the recovered clock domain
  sata_neg_pkg::rx_ind_s rx_s;

  sata_neg_sync #(
    .WIDTH ($bits(sata_neg_pkg::rx_ind_s))
  ) u_rx_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  (i_rx),
    .o_sync   (rx_s)
  );

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TONE  = 4'h1,
    ST_ALIGN = 4'h2,
    ST_LINK  = 4'h4,
    ST_FAIL  = 4'h8
  } state_e;

  state_e      state_q;
  state_e      state_d;
  logic [7:0]  det_cnt_q;
  logic [1:0]  det_gen_q;
  logic [15:0] wait_q;
  logic [1:0]  gen_q;
  logic        restart_q;
  logic        link_up_q;
  logic [1:0]  link_gen_q;

  // gen3 align is never treated as a valid detection
  logic align_ok;
  assign align_ok = rx_s.align_seen &&
                    (rx_s.align_gen == sata_neg_pkg::GEN2 ||
                     rx_s.align_gen == sata_neg_pkg::GEN1);

  logic detected;
  // the rate must still match the one counted, or a last-cycle change would be answered
  assign detected = align_ok &&
                    (rx_s.align_gen == det_gen_q) &&
                    (det_cnt_q == 8'(DETECT_CYCLES - 1));

  // cominit from the drive is handled exactly like a software port reset
  logic restart;
  assign restart = i_port_reset || rx_s.cominit;

  // ----------------------------------------------------------------
  // detection filter
  // ----------------------------------------------------------------
  // aliasing gives short false hits; demand a steady rate for a while
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      det_cnt_q <= '0;
      det_gen_q <= sata_neg_pkg::GEN_NONE;
    end else if (restart || state_q != ST_TONE || !align_ok || rx_s.align_gen != det_gen_q) begin
      det_cnt_q <= '0;
      det_gen_q <= align_ok ? rx_s.align_gen : sata_neg_pkg::GEN_NONE;
    end else if (!detected) begin
      det_cnt_q <= det_cnt_q + 8'h01;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_TONE: begin
        if (detected) begin
          state_d = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (rx_s.sync_seen) begin
          state_d = ST_LINK;
        end else if (wait_q == 16'h0000) begin
          state_d = ST_FAIL;
        end
      end
      ST_LINK: begin
        // a live link holds until port reset or cominit
        state_d = ST_LINK;
      end
      ST_FAIL: begin
        state_d = ST_TONE;
      end
      default: begin
        state_d = ST_TONE;
      end
    endcase
    if (restart) begin
      state_d = ST_TONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_TONE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // answer timeout and negotiated rate
  // ----------------------------------------------------------------
  // without sync within a drive step the drive has moved on; fall back to tone
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q <= '0;
    end else if (state_q == ST_TONE) begin
      wait_q <= 16'(ANSWER_WAIT - 1);
    end else if (state_q == ST_ALIGN && wait_q != 16'h0000) begin
      wait_q <= wait_q - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gen_q <= sata_neg_pkg::GEN1;
    end else if (state_q == ST_TONE && state_d == ST_ALIGN) begin
      gen_q <= det_gen_q;
    end else if (state_d == ST_TONE) begin
      gen_q <= sata_neg_pkg::GEN1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= restart || state_q == ST_FAIL;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx.pattern <= sata_neg_pkg::TX_TONE;
      o_tx.gen     <= sata_neg_pkg::GEN1;
    end else begin
      case (state_d)
        ST_ALIGN: begin
          o_tx.pattern <= sata_neg_pkg::TX_ALIGN;
          o_tx.gen     <= (state_q == ST_TONE) ? det_gen_q : gen_q;
        end
        ST_LINK: begin
          o_tx.pattern <= sata_neg_pkg::TX_SYNC;
          o_tx.gen     <= gen_q;
        end
        ST_FAIL: begin
          o_tx.pattern <= sata_neg_pkg::TX_IDLE;
          o_tx.gen     <= sata_neg_pkg::GEN1;
        end
        default: begin
          o_tx.pattern <= sata_neg_pkg::TX_TONE;
          o_tx.gen     <= sata_neg_pkg::GEN1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link report
  // ----------------------------------------------------------------
  // registered so the reported rate never glitches while state settles
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_up_q  <= 1'b0;
      link_gen_q <= sata_neg_pkg::GEN_NONE;
    end else if (state_d == ST_LINK) begin
      link_up_q  <= 1'b1;
      link_gen_q <= gen_q;
    end else begin
      link_up_q  <= 1'b0;
      link_gen_q <= sata_neg_pkg::GEN_NONE;
    end
  end

  assign o_link_up  = link_up_q;
  assign o_link_gen = link_gen_q;
  assign o_restart  = restart_q;

endmodule // sata_host_speed_negotiation

// ===== sata_neg_pkg.sv
// shared constants and types for the host speed negotiation block
package sata_neg_pkg;

  // link generations as seen by the receive detector
  localparam logic [1:0] GEN1 = 2'h1;
  localparam logic [1:0] GEN2 = 2'h2;
  localparam logic [1:0] GEN3 = 2'h3;
  localparam logic [1:0] GEN_NONE = 2'h0;

  // transmit pattern select
  localparam logic [1:0] TX_IDLE  = 2'h0;
  localparam logic [1:0] TX_TONE  = 2'h1;
  localparam logic [1:0] TX_ALIGN = 2'h2;
  localparam logic [1:0] TX_SYNC  = 2'h3;

  // drive timeout per speed step, and the host's give-up time for an answer
  localparam int DRIVE_TIMEOUT_NS = 54600;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ANSWER_WAIT_CYC  = (DRIVE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // detection must persist this many cycles before it is believed
  localparam int DETECT_CYC       = 16;

  // raw indications from the receive phy
  typedef struct packed {
    logic       align_seen;
    logic [1:0] align_gen;
    logic       sync_seen;
    logic       cominit;
  } rx_ind_s;

  // transmit control towards the phy
  typedef struct packed {
    logic [1:0] pattern;
    logic [1:0] gen;
  } tx_ctl_s;

endpackage

// ===== sata_neg_properties.sv
// assertions on the host speed negotiation ports
`timescale 1ns/1ps
module sata_neg_properties #(parameter int ANSWER_WAIT = 50) (
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire logic                  i_port_reset,
  input wire sata_neg_pkg::rx_ind_s i_rx,
  input wire sata_neg_pkg::tx_ctl_s o_tx,
  input wire logic                  o_link_up,
  input wire logic [1:0]            o_link_gen,
  input wire logic                  o_restart
);
  // slack of two edges for the fail idle cycle
  localparam int WAIT_MAX = ANSWER_WAIT + 2;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_align_on;
    $rose(o_tx.pattern == sata_neg_pkg::TX_ALIGN);
  endsequence
  sequence s_retone;
    o_restart && o_tx.pattern == sata_neg_pkg::TX_TONE;
  endsequence
  a_reset_pulse: assert property (i_port_reset |=> o_restart)
    else $error("port reset gave no restart pulse");
  a_fail_retone: assert property (o_tx.pattern == sata_neg_pkg::TX_IDLE |=> s_retone)
    else $error("give up did not restart tone");
  a_tone_gen1: assert property (o_tx.pattern == sata_neg_pkg::TX_TONE |-> o_tx.gen == sata_neg_pkg::GEN1)
    else $error("tone not at gen1");
  a_align_gen: assert property (o_tx.pattern == sata_neg_pkg::TX_ALIGN |-> o_tx.gen != sata_neg_pkg::GEN3)
    else $error("align answered at gen3");
  a_reset_tone: assert property (i_port_reset |=> o_tx.pattern == sata_neg_pkg::TX_TONE && !o_link_up)
    else $error("port reset did not restart");
  a_link_sync: assert property (o_link_up |-> o_tx.pattern == sata_neg_pkg::TX_SYNC && o_link_gen == o_tx.gen)
    else $error("link up without sync");
  a_gen_idle: assert property (!o_link_up |-> o_link_gen == sata_neg_pkg::GEN_NONE)
    else $error("link gen while down");
  a_link_from: assert property ($rose(o_link_up) |-> $past(o_tx.pattern) == sata_neg_pkg::TX_ALIGN)
    else $error("link up not from align");
  a_align_ends: assert property (s_align_on |-> ##[1:WAIT_MAX] o_tx.pattern != sata_neg_pkg::TX_ALIGN)
    else $error("align stuck");
endmodule // sata_neg_properties
bind sata_host_speed_negotiation sata_neg_properties #(.ANSWER_WAIT(ANSWER_WAIT)) u_props (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_port_reset(i_port_reset), .i_rx(i_rx), .o_tx(o_tx), .o_link_up(o_link_up),
  .o_link_gen(o_link_gen), .o_restart(o_restart));

// ===== sata_neg_sync.sv
// two-flop synchroniser for a vector of asynchronous indications
`timescale 1ns/1ps
module sata_neg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // sata_neg_sync

// ===== testbench.sv
// self-checking bench for the host speed negotiation block
`timescale 1ns/1ps
module testbench;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  port_reset = 1'b0;
  localparam int         ANS_WAIT = 50;
  logic                  en = 1'b0;
  logic                  deaf = 1'b0;
  logic [1:0]            max_gen = 2'h2;
  sata_neg_pkg::rx_ind_s rx;
  sata_neg_pkg::tx_ctl_s tx;
  logic                  link_up;
  logic [1:0]            link_gen;
  logic                  restart;
  int                    err_count = 0;
  int                    checks = 0;
  int                    cyc = 0;
  int                    n;
  logic [31:0]           seed = 32'h3B;
  always #5 clk = ~clk;
  sata_host_speed_negotiation #(.DETECT_CYCLES(4), .ANSWER_WAIT(ANS_WAIT)) u_dut (.i_clk(clk), .i_resetn(resetn),
    .i_port_reset(port_reset), .i_rx(rx), .o_tx(tx), .o_link_up(link_up), .o_link_gen(link_gen), .o_restart(restart));
  sata_drive_model #(.TIMEOUT(100)) u_drive (.i_clk(clk), .i_en(en), .i_deaf(deaf), .i_max_gen(max_gen),
    .i_tx(tx), .o_rx(rx));
  function automatic logic [1:0] exp_gen(input logic [1:0] mg);
    return (mg == sata_neg_pkg::GEN3) ? sata_neg_pkg::GEN2 : mg;
  endfunction
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // one negotiation against a drive of the given top speed
  // --------------------------------------------------------------
  task automatic restart_drive(input logic [1:0] mg, input logic df);
    @(negedge clk);
    en = 1'b0;
    deaf = df;
    max_gen = mg;
    port_reset = 1'b1;
    @(negedge clk);
    port_reset = 1'b0;
    repeat (2) @(negedge clk);
    en = 1'b1;
  endtask
  task automatic run(input logic [1:0] mg);
    restart_drive(mg, 1'b0);
    repeat (60) @(negedge clk);
    if (mg == sata_neg_pkg::GEN3) chk({4'h0, tx}, {4'h0, sata_neg_pkg::TX_TONE, sata_neg_pkg::GEN1});
    for (int i = 0; i < 400 && link_up !== 1'b1; i++) @(negedge clk);
    chk({4'h0, tx.pattern, link_gen}, {4'h0, sata_neg_pkg::TX_SYNC, exp_gen(mg)});
  endtask
  // drive never hears the host: host gives up, later cominit restarts it
  task automatic run_deaf();
    restart_drive(sata_neg_pkg::GEN1, 1'b1);
    for (int i = 0; i < 100 && tx.pattern != sata_neg_pkg::TX_ALIGN; i++) @(negedge clk);
    n = 0;
    while (tx.pattern == sata_neg_pkg::TX_ALIGN && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'(ANS_WAIT));
    chk({4'h0, tx}, {4'h0, sata_neg_pkg::TX_IDLE, sata_neg_pkg::GEN1});
    @(negedge clk);
    chk({4'h0, tx.pattern, restart, link_up}, {4'h0, sata_neg_pkg::TX_TONE, 1'b1, 1'b0});
    for (int i = 0; i < 200 && rx.cominit !== 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk({4'h0, tx.pattern, restart, link_up}, {4'h0, sata_neg_pkg::TX_TONE, 1'b1, 1'b0});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    run(sata_neg_pkg::GEN2);
    run(sata_neg_pkg::GEN3);
    run(sata_neg_pkg::GEN1);
    port_reset = 1'b1;
    @(negedge clk);
    port_reset = 1'b0;
    chk({4'h0, tx.pattern, restart, link_up}, {4'h0, sata_neg_pkg::TX_TONE, 1'b1, 1'b0});
    run_deaf();
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      run(2'(seed % 3) + 2'h1);
    end
    stop_test();
  end
endmodule // testbench
